// file: hdl/gcs_pkg.sv
// Constants, codes and carrier types of the copper status register bank
package gcs_pkg;

  // ****************************************
  // Register indexes (byte address is four times the index)
  // ****************************************
  localparam int GCS_ADDR_W = 12;
  localparam int GCS_IDX_W = 6;
  localparam logic [5:0] GCS_IDX_CTRL0 = 6'h00;
  localparam logic [5:0] GCS_IDX_GSTAT = 6'h0a;
  localparam logic [5:0] GCS_IDX_MMDCTL = 6'h0d;
  localparam logic [5:0] GCS_IDX_MMDAD = 6'h0e;
  localparam logic [5:0] GCS_IDX_EXTST = 6'h0f;
  localparam logic [5:0] GCS_IDX_CUCTL = 6'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GCS_CTRL0_SWRST = 15;
  localparam int GCS_IDLE_W = 8;
  localparam int GCS_FN_HI = 15;
  localparam int GCS_FN_LO = 14;
  localparam int GCS_DEV_W = 5;
  localparam int GCS_ED_HI = 9;
  localparam int GCS_ED_LO = 8;
  localparam int GCS_XO_HI = 6;
  localparam int GCS_XO_LO = 5;
  localparam int GCS_CU_RSV = 4;

  // ****************************************
  // Fixed values and reset values
  // ****************************************
  localparam logic [15:0] GCS_EXTST_VALUE = 16'h3000;
  localparam logic [7:0] GCS_IDLE_MAX = 8'hff;
  localparam logic [1:0] GCS_ED_RST = 2'h0;
  localparam logic [1:0] GCS_XO_RST = 2'h1;
  localparam logic [1:0] GCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] GCS_RESP_SLVERR = 2'h2;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    GCS_FN_ADDR = 2'h0,
    GCS_FN_DATA = 2'h1,
    GCS_FN_INC_RW = 2'h2,
    GCS_FN_INC_WR = 2'h3
  } gcs_func_t;

  localparam logic [1:0] GCS_XO_MDI = 2'h0;
  localparam logic [1:0] GCS_XO_MDIX = 2'h1;
  localparam logic [1:0] GCS_XO_AUTO = 2'h3;
  localparam logic [1:0] GCS_ED_SENSE = 2'h2;
  localparam logic [1:0] GCS_ED_PULSE = 2'h3;

  typedef enum logic [1:0] {
    GCS_RD_IDLE = 2'b01,
    GCS_RD_RESP = 2'b10
  } gcs_rdst_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic msFault;
    logic msMaster;
    logic localRxOk;
    logic remoteRxOk;
    logic lpFullCap;
    logic lpHalfCap;
    logic idleErr;
  } gcs_phy_status_t;

  typedef struct packed {
    logic [1:0] energyMode;
    logic [1:0] crossMode;
    logic swReset;
  } gcs_mode_t;

endpackage

// file: hdl/gcs_mmd_store.sv
// Extended device address registers and data storage behind the indirect pair
`timescale 1ns/1ps
module gcs_mmd_store
  import gcs_pkg::*;
#(
  parameter int NUM_DEV = 32,
  parameter int WORD_AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic swReset,
  // Access
  input wire gcs_func_t func,
  input wire logic [GCS_DEV_W-1:0] devSel,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData
);

  logic [15:0] addr_ff [NUM_DEV];
  logic [15:0] mem [NUM_DEV * (2 ** WORD_AW)];
  wire logic dataPhase = (func != GCS_FN_ADDR);
  wire logic incPulse = (wrEn && (func == GCS_FN_INC_RW || func == GCS_FN_INC_WR))
    || (rdEn && func == GCS_FN_INC_RW); // R8
  wire logic [GCS_DEV_W+WORD_AW-1:0] memIdx = {devSel, addr_ff[devSel][WORD_AW-1:0]};

  // ****************************************
  // Per-device address registers
  // ****************************************
  genvar d;
  generate
    for (d = 0; d < NUM_DEV; d++) begin : g_dev
      wire logic hit = (devSel == GCS_DEV_W'(d));
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          addr_ff[d] <= 16'h0000;
        end else if (swReset) begin
          addr_ff[d] <= 16'h0000;
        end else if (hit && wrEn && !dataPhase) begin
          addr_ff[d] <= wrData; // R9
        end else if (hit && incPulse) begin
          addr_ff[d] <= addr_ff[d] + 16'h0001; // R8
        end
      end
    end
  endgenerate

  // Storage keeps its contents over software reset
  always_ff @(posedge clk_sys) begin
    if (wrEn && dataPhase) begin
      mem[memIdx] <= wrData; // R9
    end
  end

  assign rdData = dataPhase ? mem[memIdx] : addr_ff[devSel]; // R9

endmodule

// file: hdl/gcs_regs.sv
// Copper gigabit status register bank with AXI4-Lite slave
//
// Operation
// (R1) Master/slave fault bit 15 latches on fault, clears when status is read.
// (R2) Bit 14 reads 1 when resolved master, 0 when slave.
// (R3) Bit 13 reports local receiver health, 1 when good.
// (R4) Bit 12 reports remote receiver health learned from link, 1 when good.
// (R5) Bits 11 and 10 show partner full and half duplex gigabit ability.
// (R6) Bits 7:0 count idle errors since last read, restarting after each read.
// (R7) Idle error counter stops at all ones, never wraps.
// (R8) Function field 15:14: address, data, increment on all, increment on writes.
// (R9) Address/data register reaches device address register or addressed data word.
// (R10) Control bits 4:0 select which extended device is reached.
// (R11) Extended status reads bits 15:14 zero and bits 13:12 one.
// (R12) Energy field 9:8: 0x off, 10 sense, 11 sense and send pulses.
// (R13) Hardware reset loads both energy bits with inverted sleep-disable strap.
// (R14) Crossover field 6:5: 11 auto, 01 crossed, 00 straight, 10 reserved.
// (R15) New crossover mode takes effect only at next software reset.
// (R16) Hardware reset crossover default is 01 with strap low, 11 with strap high.
// (R17) Writing 1 to control bit 15 issues a software reset.
// (R18) Reserved bits read zero, ignore writes (copper control bit 4 is stored and reads back); latched flags hold until read; software reset clears them too.
`timescale 1ns/1ps
module gcs_regs
  import gcs_pkg::*;
#(
  parameter int NUM_DEV = 32,
  parameter int WORD_AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Straps
  input wire logic sleepDisableStrap,
  input wire logic crossoverEnableStrap,
  // Transceiver status
  input wire gcs_phy_status_t phyStatus,
  // Mode outputs
  output gcs_mode_t modeOut,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [GCS_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [GCS_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ****************************************
  // State
  // ****************************************
  logic awHave_ff, wHave_ff, bvalid_ff;
  logic [GCS_ADDR_W-1:0] awAddr_ff;
  logic [15:0] wData_ff;
  logic [1:0] wStrb_ff;
  logic [1:0] bresp_ff;
  gcs_rdst_t rdSt_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic strapDone_ff;
  logic fault_ff;
  logic [GCS_IDLE_W-1:0] idleCnt_ff;
  gcs_func_t func_ff;
  logic [GCS_DEV_W-1:0] devSel_ff;
  logic [1:0] energy_ff;
  logic [1:0] crossPend_ff;
  logic [1:0] crossApplied_ff;
  logic cuRsv_ff;
  logic swReset_ff;
  logic [15:0] storeRd;

  // ****************************************
  // Decode
  // ****************************************
  wire logic awTake = s_axi_awvalid && !awHave_ff;
  wire logic wTake = s_axi_wvalid && !wHave_ff;
  wire logic wrCommit = awHave_ff && wHave_ff && !bvalid_ff;
  wire logic [GCS_IDX_W-1:0] wIdx = awAddr_ff[GCS_IDX_W+1:2];
  wire logic wUpperZero = (awAddr_ff[GCS_ADDR_W-1:GCS_IDX_W+2] == '0);
  wire logic arTake = s_axi_arvalid && (rdSt_ff == GCS_RD_IDLE);
  wire logic [GCS_IDX_W-1:0] rIdx = s_axi_araddr[GCS_IDX_W+1:2];
  wire logic rUpperZero = (s_axi_araddr[GCS_ADDR_W-1:GCS_IDX_W+2] == '0);

  function automatic logic mapped(input logic [GCS_IDX_W-1:0] idx);
    mapped = (idx == GCS_IDX_CTRL0) || (idx == GCS_IDX_GSTAT) || (idx == GCS_IDX_MMDCTL)
      || (idx == GCS_IDX_MMDAD) || (idx == GCS_IDX_EXTST) || (idx == GCS_IDX_CUCTL);
  endfunction

  wire logic wHit = wUpperZero && mapped(wIdx);
  wire logic rHit = rUpperZero && mapped(rIdx);
  wire logic readGstat = arTake && rHit && (rIdx == GCS_IDX_GSTAT);
  wire logic readMmdAd = arTake && rHit && (rIdx == GCS_IDX_MMDAD);
  wire logic wrCtrl0 = wrCommit && wHit && (wIdx == GCS_IDX_CTRL0);
  wire logic wrMmdCtl = wrCommit && wHit && (wIdx == GCS_IDX_MMDCTL);
  wire logic wrMmdAd = wrCommit && wHit && (wIdx == GCS_IDX_MMDAD);
  wire logic wrCuCtl = wrCommit && wHit && (wIdx == GCS_IDX_CUCTL);

  // ****************************************
  // Register images
  // ****************************************
  wire logic [15:0] gstatVal = {fault_ff, phyStatus.msMaster, // R1 R2
    phyStatus.localRxOk, phyStatus.remoteRxOk, // R3 R4
    phyStatus.lpFullCap, phyStatus.lpHalfCap, 2'h0, idleCnt_ff}; // R5 R6 R18
  wire logic [15:0] mmdCtlVal = {func_ff, 9'h000, devSel_ff}; // R8 R10 R18
  wire logic [15:0] cuCtlVal = {6'h00, energy_ff, 1'b0, crossPend_ff, cuRsv_ff, 4'h0}; // R18

  // Images come in as arguments so that the continuous uses follow every change
  function automatic logic [15:0] regValue(input logic [GCS_IDX_W-1:0] idx,
      input logic [15:0] gs, input logic [15:0] mc, input logic [15:0] ad, input logic [15:0] cu);
    case (idx)
      GCS_IDX_GSTAT: regValue = gs;
      GCS_IDX_MMDCTL: regValue = mc;
      GCS_IDX_MMDAD: regValue = ad; // R9
      GCS_IDX_EXTST: regValue = GCS_EXTST_VALUE; // R11
      GCS_IDX_CUCTL: regValue = cu;
      default: regValue = 16'h0000; // R17 R18
    endcase
  endfunction

  // Byte lanes merge with the current image so a single-lane write keeps the other byte
  wire logic [15:0] curW = regValue(wIdx, gstatVal, mmdCtlVal, storeRd, cuCtlVal);
  wire logic [15:0] wMerged = {wStrb_ff[1] ? wData_ff[15:8] : curW[15:8],
    wStrb_ff[0] ? wData_ff[7:0] : curW[7:0]};
  wire logic [15:0] rdImage = regValue(rIdx, gstatVal, mmdCtlVal, storeRd, cuCtlVal);

  // ****************************************
  // Status flags and counter
  // ****************************************
  wire logic statClr = readGstat || swReset_ff;
  // A fault in the clearing cycle survives
  wire logic nxt_fault = phyStatus.msFault || (fault_ff && !statClr); // R1 R18
  wire logic cntFull = (idleCnt_ff == GCS_IDLE_MAX);
  wire logic [GCS_IDLE_W-1:0] cntInc = idleCnt_ff + GCS_IDLE_W'(1);
  wire logic [GCS_IDLE_W-1:0] nxt_idleCnt = statClr ? GCS_IDLE_W'(phyStatus.idleErr) // R6
    : ((phyStatus.idleErr && !cntFull) ? cntInc : idleCnt_ff); // R7

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_ff <= 1'b0;
      idleCnt_ff <= '0;
    end else begin
      fault_ff <= nxt_fault;
      idleCnt_ff <= nxt_idleCnt;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  wire logic nxt_swReset = wrCtrl0 && wMerged[GCS_CTRL0_SWRST]; // R17

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      swReset_ff <= 1'b0;
    end else begin
      swReset_ff <= nxt_swReset;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      func_ff <= GCS_FN_ADDR;
      devSel_ff <= '0;
    end else if (swReset_ff) begin
      func_ff <= GCS_FN_ADDR;
      devSel_ff <= '0;
    end else if (wrMmdCtl) begin
      func_ff <= gcs_func_t'(wMerged[GCS_FN_HI:GCS_FN_LO]); // R8
      devSel_ff <= wMerged[GCS_DEV_W-1:0]; // R10
    end
  end

  // Straps are sampled on the first edge after reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strapDone_ff <= 1'b0;
      energy_ff <= GCS_ED_RST;
      crossPend_ff <= GCS_XO_RST;
      crossApplied_ff <= GCS_XO_RST;
      cuRsv_ff <= 1'b0;
    end else if (!strapDone_ff) begin
      strapDone_ff <= 1'b1;
      energy_ff <= {2{~sleepDisableStrap}}; // R13
      crossPend_ff <= crossoverEnableStrap ? GCS_XO_AUTO : GCS_XO_MDIX; // R16
      crossApplied_ff <= crossoverEnableStrap ? GCS_XO_AUTO : GCS_XO_MDIX; // R16
    end else begin
      if (wrCuCtl) begin
        energy_ff <= wMerged[GCS_ED_HI:GCS_ED_LO]; // R12
        crossPend_ff <= wMerged[GCS_XO_HI:GCS_XO_LO]; // R14
        cuRsv_ff <= wMerged[GCS_CU_RSV];
      end
      // Changing wiring mid-link is disruptive, so it waits for software reset
      if (swReset_ff) begin
        crossApplied_ff <= crossPend_ff; // R15
      end
    end
  end

  assign modeOut = '{energyMode: energy_ff, crossMode: crossApplied_ff, // R12 R14
    swReset: swReset_ff};

  // ****************************************
  // Indirect access storage
  // ****************************************
  gcs_mmd_store #(
    .NUM_DEV(NUM_DEV),
    .WORD_AW(WORD_AW)
  ) u_store (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .swReset(swReset_ff),
    .func(func_ff),
    .devSel(devSel_ff),
    .wrEn(wrMmdAd),
    .rdEn(readMmdAd),
    .wrData(wMerged),
    .rdData(storeRd)
  );

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awHave_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (awTake) begin
      awHave_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (wrCommit) begin
      awHave_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wHave_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (wTake) begin
      wHave_ff <= 1'b1;
      wData_ff <= s_axi_wdata[15:0];
      wStrb_ff <= s_axi_wstrb[1:0];
    end else if (wrCommit) begin
      wHave_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= GCS_RESP_OKAY;
    end else if (wrCommit) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wHit ? GCS_RESP_OKAY : GCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = !awHave_ff;
  assign s_axi_wready = !wHave_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdSt_ff <= GCS_RD_IDLE;
      rdata_ff <= '0;
      rresp_ff <= GCS_RESP_OKAY;
    end else begin
      case (rdSt_ff)
        GCS_RD_IDLE: begin
          if (arTake) begin
            rdSt_ff <= GCS_RD_RESP;
            rdata_ff <= rHit ? {16'h0000, rdImage} : 32'h0000_0000;
            rresp_ff <= rHit ? GCS_RESP_OKAY : GCS_RESP_SLVERR;
          end
        end
        GCS_RD_RESP: begin
          if (s_axi_rready) begin
            rdSt_ff <= GCS_RD_IDLE;
          end
        end
        default: rdSt_ff <= GCS_RD_IDLE;
      endcase
    end
  end

  assign s_axi_arready = (rdSt_ff == GCS_RD_IDLE);
  assign s_axi_rvalid = (rdSt_ff == GCS_RD_RESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

// file: tb/gcs_regs_assertions.sv
// Port-level checks of the copper status register bank
`timescale 1ns/1ps
module gcs_regs_assertions
  import gcs_pkg::*;
#(
  parameter int NUM_DEV = 32,
  parameter int WORD_AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Straps, status and modes
  input wire logic sleepDisableStrap,
  input wire logic crossoverEnableStrap,
  input wire gcs_phy_status_t phyStatus,
  input wire gcs_mode_t modeOut,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [GCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [GCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire statusRd = rdTake && s_axi_araddr[11:2] == 10'h00a;

  // ****
  // Properties
  // ****
  rd_answer_a: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read answer late");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("Read not closed");
  rd_unmapped_a: assert property (rdTake && s_axi_araddr[11:2] > 10'h010
    |=> s_axi_rresp == GCS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("Unmapped read");
  ext_fixed_a: assert property (rdTake && s_axi_araddr[11:2] == 10'h00f
    |=> s_axi_rdata == 32'h3000) else $error("Extended status wrong");
  live_bits_a: assert property (statusRd
    |=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[14:8] == {$past(phyStatus[5:1]), 2'b00})
    else $error("Live bits wrong");
  fault_latch_a: assert property (statusRd && $past(nrst) && $past(phyStatus.msFault)
    && !$past(modeOut.swReset) |=> s_axi_rdata[15]) else $error("Fault not latched");
  sw_pulse_a: assert property (modeOut.swReset |=> !modeOut.swReset)
    else $error("Reset pulse too long");
  cross_hold_a: assert property ($past(nrst, 2) && $changed(modeOut.crossMode)
    |-> $past(modeOut.swReset)) else $error("Crossover changed early");
  energy_apply_a: assert property ($past(nrst, 2) && $changed(modeOut.energyMode)
    |-> $rose(s_axi_bvalid)) else $error("Energy changed without a write");
endmodule

bind gcs_regs gcs_regs_assertions #(.NUM_DEV(NUM_DEV), .WORD_AW(WORD_AW)) i_gcs_regs_assertions (
  .clk_sys, .nrst, .sleepDisableStrap, .crossoverEnableStrap, .phyStatus, .modeOut,
  .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// file: tb/tb.sv
// Self-checking bench for the copper status register bank
`timescale 1ns/1ps
module tb;
  import gcs_pkg::*;
  logic clk_sys, nrst, sleepDisableStrap, crossoverEnableStrap;
  gcs_phy_status_t phyStatus;
  gcs_mode_t modeOut;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] dev;
  int err_count, check_count;

  gcs_regs i_gcs_regs (.clk_sys, .nrst, .sleepDisableStrap, .crossoverEnableStrap, .phyStatus,
    .modeOut, .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // ****
  // Expectations and bus tasks
  // ****
  function automatic logic [15:0] stat(logic f, logic [4:0] live, logic [7:0] n);
    return {f, live, 2'b00, n};
  endfunction
  function automatic logic [15:0] cuv(logic [1:0] ed, logic [1:0] xo, logic b4);
    return {6'h0, ed, 1'b0, xo, b4, 4'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    bit ah, wh;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0, d};
    bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge clk_sys);
      if (!ah && awready) begin
        ah = 1;
        awvalid <= 1'b0;
      end
      if (!wh && wready) begin
        wh = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wo(input logic [11:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, {16'h0, e}, d);
    chk("rresp", 32'h0, {30'h0, r});
  endtask
  task automatic fn(input gcs_func_t f);
    wo(12'h034, {f, 9'h0, dev});
  endtask
  task automatic hwReset(input logic s, input logic x);
    sleepDisableStrap <= s;
    crossoverEnableStrap <= x;
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("energy", {30'h0, {2{~s}}}, {30'h0, modeOut.energyMode});
    chk("cross", x ? 32'h3 : 32'h1, {30'h0, modeOut.crossMode});
    rc("cuctl", 12'h040, cuv({2{~s}}, x ? 2'h3 : 2'h1, 1'b0));
  endtask
  // Fault stays up with the burst; a burst always has one error at least
  task automatic events(input int n, input bit f);
    @(posedge clk_sys);
    phyStatus.msFault <= f;
    repeat (n) begin
      phyStatus.idleErr <= 1'b1;
      @(posedge clk_sys);
    end
    phyStatus.msFault <= 1'b0;
    phyStatus.idleErr <= 1'b0;
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****
  // Clock and watchdog
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    logic [4:0] live;
    logic [1:0] r;
    logic [31:0] d;
    logic [15:0] dv[4];
    logic [1:0] xt[4];
    logic [1:0] prevX;
    logic s, x;
    int n;
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, phyStatus, dev} = '0;
    {sleepDisableStrap, crossoverEnableStrap} = '0;
    xt = '{2'h0, 2'h1, 2'h3, 2'h0};
    void'($urandom(11));
    s = 1'($urandom);
    x = 1'($urandom);
    hwReset(s, x);
    prevX = x ? 2'h3 : 2'h1;
    rc("extst", 12'h03c, GCS_EXTST_VALUE);
    wo(12'h03c, 16'hffff);
    rc("extst", 12'h03c, 16'h3000);
    rd(12'h044, d, r);
    chk("unmapped rresp", {30'h0, GCS_RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    wr(12'h100, 16'h8000, r);
    chk("unmapped bresp", {30'h0, GCS_RESP_SLVERR}, {30'h0, r});
    for (int i = 0; i < 4; i++) begin
      live = 5'($urandom);
      n = 1 + $urandom_range(40);
      phyStatus[5:1] <= live;
      events(n, i[0]);
      rc("status", 12'h028, stat(i[0], live, 8'(n)));
      rc("status", 12'h028, stat(1'b0, live, 8'h0));
    end
    events(300, 1'b0);
    rc("status", 12'h028, stat(1'b0, live, 8'hff));
    // Fault held across the read take: the set must win over the read clear
    phyStatus.msFault <= 1'b1;
    rc("status", 12'h028, stat(1'b1, live, 8'h0));
    phyStatus.msFault <= 1'b0;
    rc("status", 12'h028, stat(1'b1, live, 8'h0));
    rc("status", 12'h028, stat(1'b0, live, 8'h0));
    dev = 5'($urandom);
    foreach (dv[k]) dv[k] = 16'($urandom);
    wo(12'h034, {2'b00, 9'h1ff, dev});
    rc("mmdctl", 12'h034, {11'h0, dev});
    wo(12'h038, 16'h0004);
    rc("mmdadr", 12'h038, 16'h0004);
    fn(GCS_FN_DATA);
    wo(12'h038, dv[0]);
    rc("mmddat", 12'h038, dv[0]);
    rc("mmddat", 12'h038, dv[0]);
    fn(GCS_FN_INC_RW);
    wo(12'h038, dv[1]);
    wo(12'h038, dv[2]);
    fn(GCS_FN_ADDR);
    rc("mmdadr", 12'h038, 16'h0006);
    wo(12'h038, 16'h0004);
    fn(GCS_FN_INC_WR);
    rc("mmddat", 12'h038, dv[1]);
    rc("mmddat", 12'h038, dv[1]);
    wo(12'h038, dv[3]);
    rc("mmddat", 12'h038, dv[2]);
    fn(GCS_FN_ADDR);
    wo(12'h038, 16'h0004);
    fn(GCS_FN_INC_RW);
    rc("mmddat", 12'h038, dv[3]);
    rc("mmddat", 12'h038, dv[2]);
    for (int i = 0; i < 4; i++) begin
      wo(12'h040, {6'h3f, 2'(i), 1'b1, xt[i], 5'h1f});
      rc("cuctl", 12'h040, cuv(2'(i), xt[i], 1'b1));
      chk("energy", i, {30'h0, modeOut.energyMode});
      chk("cross", {30'h0, prevX}, {30'h0, modeOut.crossMode});
      wo(12'h000, 16'h8000);
      repeat (3) @(posedge clk_sys);
      chk("cross", {30'h0, xt[i]}, {30'h0, modeOut.crossMode});
      prevX = xt[i];
    end
    rc("ctrl0", 12'h000, 16'h0);
    rc("mmdctl", 12'h034, 16'h0);
    hwReset(~s, ~x);
    rc("status", 12'h028, stat(1'b0, live, 8'h0));
    conclude();
  end
endmodule
